/* hw/urxfc_pkg.sv */
// Constants for the receive holding stage and flow control of a UART.
// Assumes one 40 MHz core clock and an 8-bit plain register port.
package urxfc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int URXFC_FIFO_DEPTH = 64; // Receive FIFO entries
	localparam int URXFC_TAG_W = 3; // Error tags per entry
	localparam logic [6:0] URXFC_FIFO_FULL = 7'h40; // Level when full
	localparam int URXFC_ADDR_W = 5; // Register index width

	////////////////////////////////////////////////////////////////////////
	// Register indices
	localparam logic [4:0] URXFC_RX_HOLDING = 5'h00;
	localparam logic [4:0] URXFC_INT_ENABLE = 5'h01;
	localparam logic [4:0] URXFC_INT_STATUS = 5'h02;
	localparam logic [4:0] URXFC_FIFO_CTRL = 5'h03;
	localparam logic [4:0] URXFC_LINE_CTRL = 5'h04;
	localparam logic [4:0] URXFC_MODEM_CTRL = 5'h05;
	localparam logic [4:0] URXFC_LINE_STATUS = 5'h06;
	localparam logic [4:0] URXFC_ENH_FEATURE = 5'h07;
	localparam logic [4:0] URXFC_FEATURE_CTRL = 5'h08;
	localparam logic [4:0] URXFC_EXT_MODE = 5'h09;
	localparam logic [4:0] URXFC_RESUME_FIRST = 5'h0A;
	localparam logic [4:0] URXFC_RESUME_SECOND = 5'h0B;
	localparam logic [4:0] URXFC_PAUSE_FIRST = 5'h0C;
	localparam logic [4:0] URXFC_PAUSE_SECOND = 5'h0D;
	localparam logic [4:0] URXFC_RX_LEVEL = 5'h0E;
	localparam logic [4:0] URXFC_TRIG_D = 5'h0F;
	localparam logic [4:0] URXFC_HYST_D = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int URXFC_EFR_CTS = 7; // Auto CTS enable
	localparam int URXFC_EFR_RTS = 6; // Auto RTS enable
	localparam int URXFC_EFR_SPECIAL = 5; // Special character detect
	localparam int URXFC_EFR_UNLOCK = 4; // Enhanced function unlock
	localparam int URXFC_EFR_TXSW = 2; // Transmit flow chars, 2 bits
	localparam int URXFC_EFR_RXSW = 0; // Receive compare mode, 2 bits
	localparam int URXFC_IER_CTS = 7;
	localparam int URXFC_IER_RTS = 6;
	localparam int URXFC_IER_XOFF = 5;
	localparam int URXFC_IER_RXRDY = 0;
	localparam int URXFC_MCR_RTS = 1;
	localparam int URXFC_FEATURE_CTRL_REG_RS485 = 3;
	localparam int URXFC_EXT_MODE_SELECT_REG_INVERT = 3;
	localparam int URXFC_ISR_SPECIAL = 4;
	localparam int URXFC_ISR_MODEM = 5;
	localparam int URXFC_LSR_TAG = 2; // Lowest tag bit
	localparam int URXFC_FCR_TABLE = 4; // Table select, 2 bits
	localparam int URXFC_FCR_TRIG = 6; // Level select, 2 bits

	////////////////////////////////////////////////////////////////////////
	// Reset values and timing
	localparam logic [7:0] URXFC_REG_RST = 8'h00;
	localparam logic [7:0] URXFC_CHAR_RST = 8'h00;
	// Two 5-bit characters with their start and stop bits, in bit times
	localparam logic [4:0] URXFC_TWO_CHAR_BASE = 5'h0E;

	// Fixed trigger tables; index 0 is table A, level 0 the lowest.
	// Packed patterns fill the top index first, so C is listed first.
	localparam logic [2:0][3:0][6:0] URXFC_TRIG_TBL = '{
		'{7'h38, 7'h20, 7'h10, 7'h08},
		'{7'h1C, 7'h18, 7'h10, 7'h08},
		'{7'h20, 7'h10, 7'h08, 7'h04}};

	// Flow character sender states
	typedef enum logic [2:0] {
		URXFC_SEND_IDLE = 3'b001,
		URXFC_SEND_FIRST = 3'b010,
		URXFC_SEND_SECOND = 3'b100
	} urxfc_send_e;

endpackage : urxfc_pkg

/* hw/urxfc_top.sv */
// Receive holding FIFO, hardware and software flow control, special
// character detect and half-duplex direction control of one UART channel.
// Assumes receiver, transmitter and bit-rate enable share core_clk.
//
// Notes on behaviour
// - Receive FIFO: 64 entries, byte plus 3 tags
// - Holding read pops; status shows next tags
// - Auto RTS needs feature bit and RTS
// - RTS low-to-high sets modem status flag
// - Interrupt at trigger; RTS off at upper
// - RTS back on at lower limit
// - Tables A-C: neighbour levels are limits
// - Feature bit enables auto CTS halt
// - CTS deassert sets modem status flag
// - CTS halt after current character ends
// - Pause match halts transmit after character
// - Pause match sets flag, raises interrupt
// - Resume match restarts transmit, clears flag
// - Reset zeroes all four flow characters
// - Double mode needs two matching characters
// - Flow chars skip the FIFO except a broken pair's first and the special char
// - Send pause two characters after crossing
// - Send resume at lower limit, table D below
// - Special character stored and flagged
// - Compare only selected word length bits
// - Half-duplex: RTS high when transmit idle
// - Direction output polarity inverts on bit
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module urxfc_top
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic rxCharValid,
	input wire logic [7:0] rxChar,
	input wire logic [2:0] rxErrTags,
	input wire logic bitTick,
	input wire logic txActive,
	input wire logic ctsPinN,
	output logic rtsPinN,
	output logic txHalt,
	output logic flowReq,
	output logic [7:0] flowChar,
	input wire logic flowAck,
	output logic intPending
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [63:0][10:0] mem; // FIFO entries, tags on top
		logic [5:0] wrPtr;
		logic [5:0] rdPtr;
		logic [6:0] count; // Entries held
		logic [7:0] int_enable_reg;
		logic [7:0] fifo_ctrl_reg;
		logic [7:0] line_ctrl_reg;
		logic [7:0] modem_ctrl_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] feature_ctrl_reg;
		logic [7:0] ext_mode_select_reg;
		logic [7:0] trigD;
		logic [7:0] hystD;
		logic [3:0][7:0] chars; // Resume 1, 2, pause 1, 2
		logic [7:0] rdData;
		logic overrun;
		logic isrSpecial; // Pause or special character seen
		logic isrModem; // RTS or CTS event
		logic ctsMeta;
		logic ctsSync;
		logic ctsPrev;
		logic rtsOff; // Auto RTS holding remote off
		logic rtsPin;
		logic halt;
		logic suspended; // Pause received
		logic waitOff; // First pause char held
		logic waitOn; // First resume char held
		logic [10:0] held;
		logic replayValid;
		logic [10:0] replay;
		logic prevAbove;
		logic xoffArmed;
		logic [4:0] xoffDelay;
		logic xoffSent;
		logic sendOff; // Sender carries pause chars
		urxfc_pkg::urxfc_send_e send;
		logic [7:0] flowOut;
	} urxfc_state_s;

	urxfc_state_s s_reg;
	urxfc_state_s s_next;

	// Decoded view shared by logic and checks
	logic inValid;
	logic [10:0] inWord;
	logic [6:0] trigLvl;
	logic [6:0] upLvl;
	logic [6:0] loLvl;
	logic autoRts;
	logic popNow;
	logic isOff1;
	logic isOff2;
	logic isOn1;
	logic isOn2;
	logic isSpecial;

	////////////////////////////////////////////////////////////////////////
	// Masked compare over the selected word length
	function automatic logic charMatch(input logic [7:0] a,
		input logic [7:0] b, input logic [1:0] wl);
		logic [7:0] mask;
		mask = 8'hFF >> (2'd3 - wl);
		charMatch = ((a ^ b) & mask) == 8'h00;
	endfunction : charMatch

	////////////////////////////////////////////////////////////////////////
	// Decodes of incoming character and thresholds
	assign inValid = s_reg.replayValid || rxCharValid;
	assign inWord = s_reg.replayValid ? s_reg.replay : {rxErrTags, rxChar};
	assign isOff1 = charMatch(inWord[7:0], s_reg.chars[2], s_reg.line_ctrl_reg[1:0]);
	assign isOff2 = charMatch(inWord[7:0], s_reg.chars[3], s_reg.line_ctrl_reg[1:0]);
	assign isOn1 = charMatch(inWord[7:0], s_reg.chars[0], s_reg.line_ctrl_reg[1:0]);
	assign isOn2 = charMatch(inWord[7:0], s_reg.chars[1], s_reg.line_ctrl_reg[1:0]);
	assign isSpecial = s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_SPECIAL] && isOff2;
	assign autoRts = s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_RTS] &&
		s_reg.modem_ctrl_reg[urxfc_pkg::URXFC_MCR_RTS];
	assign popNow = regRd && regAddr == urxfc_pkg::URXFC_RX_HOLDING &&
		s_reg.count != 7'h00;

	// Trigger and hysteresis limits of the selected table
	always_comb
	begin
		logic [1:0] tbl;
		logic [1:0] lvl;
		logic [7:0] sum;
		tbl = s_reg.fifo_ctrl_reg[urxfc_pkg::URXFC_FCR_TABLE +: 2];
		lvl = s_reg.fifo_ctrl_reg[urxfc_pkg::URXFC_FCR_TRIG +: 2];
		sum = 8'h00;
		if (tbl == 2'd3)
		begin
			// Table D: programmed level plus and minus hysteresis
			trigLvl = s_reg.trigD[6:0];
			sum = {1'b0, s_reg.trigD[6:0]} + s_reg.hystD;
			upLvl = (sum > 8'h40) ? urxfc_pkg::URXFC_FIFO_FULL : sum[6:0];
			loLvl = (s_reg.trigD > s_reg.hystD) ?
				7'(s_reg.trigD - s_reg.hystD) : 7'h00;
		end
		else
		begin
			// Tables A-C: neighbouring levels are the limits
			trigLvl = urxfc_pkg::URXFC_TRIG_TBL[tbl][lvl];
			upLvl = (lvl == 2'd3) ? urxfc_pkg::URXFC_FIFO_FULL :
				urxfc_pkg::URXFC_TRIG_TBL[tbl][lvl + 2'd1];
			loLvl = (lvl == 2'd0) ? 7'h00 :
				urxfc_pkg::URXFC_TRIG_TBL[tbl][lvl - 2'd1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic push;
		logic pushOk;
		logic doOff;
		logic doOn;
		logic [10:0] pushWord;
		logic above;
		logic [1:0] txMode;
		logic xonCond;
		s_next = s_reg;
		push = 1'b0;
		pushOk = 1'b0;
		doOff = 1'b0;
		doOn = 1'b0;
		pushWord = inWord;
		above = s_reg.count >= trigLvl;
		txMode = s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_TXSW +: 2];
		// Table D resumes strictly below, tables A-C at the lower level
		xonCond = (s_reg.fifo_ctrl_reg[urxfc_pkg::URXFC_FCR_TABLE +: 2] == 2'd3) ?
			(s_reg.count < loLvl) : (s_reg.count <= loLvl);

		// CTS pin synchroniser
		s_next.ctsMeta = ctsPinN;
		s_next.ctsSync = s_reg.ctsMeta;
		s_next.ctsPrev = s_reg.ctsSync;

		// Register writes
		if (regWr)
		begin
			unique case (regAddr)
				urxfc_pkg::URXFC_INT_ENABLE: s_next.int_enable_reg = regWrData;
				urxfc_pkg::URXFC_FIFO_CTRL: s_next.fifo_ctrl_reg = regWrData;
				urxfc_pkg::URXFC_LINE_CTRL: s_next.line_ctrl_reg = regWrData;
				urxfc_pkg::URXFC_MODEM_CTRL: s_next.modem_ctrl_reg = regWrData;
				urxfc_pkg::URXFC_ENH_FEATURE: s_next.enhanced_feature_reg = regWrData;
				urxfc_pkg::URXFC_FEATURE_CTRL: s_next.feature_ctrl_reg = regWrData;
				urxfc_pkg::URXFC_EXT_MODE: s_next.ext_mode_select_reg = regWrData;
				urxfc_pkg::URXFC_RESUME_FIRST: s_next.chars[0] = regWrData;
				urxfc_pkg::URXFC_RESUME_SECOND: s_next.chars[1] = regWrData;
				urxfc_pkg::URXFC_PAUSE_FIRST: s_next.chars[2] = regWrData;
				urxfc_pkg::URXFC_PAUSE_SECOND: s_next.chars[3] = regWrData;
				urxfc_pkg::URXFC_TRIG_D: s_next.trigD = regWrData;
				urxfc_pkg::URXFC_HYST_D: s_next.hystD = regWrData;
				default: ; // Read-only or unmapped: ignored
			endcase
		end

		// Register reads; data stands in the following cycle
		s_next.rdData = 8'h00;
		if (regRd)
		begin
			unique case (regAddr)
				urxfc_pkg::URXFC_RX_HOLDING:
					s_next.rdData = popNow ?
						s_reg.mem[s_reg.rdPtr][7:0] : 8'h00;
				urxfc_pkg::URXFC_INT_STATUS:
				begin
					s_next.rdData = {2'b00, s_reg.isrModem, s_reg.isrSpecial,
						3'b000, ~intPending};
					s_next.isrModem = 1'b0;
					s_next.isrSpecial = 1'b0;
				end
				urxfc_pkg::URXFC_LINE_STATUS:
				begin
					// Tags of the character now at the head
					s_next.rdData = {3'b000, (s_reg.count != 7'h00) ?
						s_reg.mem[s_reg.rdPtr][10:8] : 3'b000,
						s_reg.overrun, s_reg.count != 7'h00};
					s_next.overrun = 1'b0;
				end
				urxfc_pkg::URXFC_RX_LEVEL: s_next.rdData = {1'b0, s_reg.count};
				urxfc_pkg::URXFC_INT_ENABLE: s_next.rdData = s_reg.int_enable_reg;
				urxfc_pkg::URXFC_FIFO_CTRL: s_next.rdData = s_reg.fifo_ctrl_reg;
				urxfc_pkg::URXFC_LINE_CTRL: s_next.rdData = s_reg.line_ctrl_reg;
				urxfc_pkg::URXFC_MODEM_CTRL: s_next.rdData = s_reg.modem_ctrl_reg;
				urxfc_pkg::URXFC_ENH_FEATURE: s_next.rdData = s_reg.enhanced_feature_reg;
				urxfc_pkg::URXFC_FEATURE_CTRL: s_next.rdData = s_reg.feature_ctrl_reg;
				urxfc_pkg::URXFC_EXT_MODE: s_next.rdData = s_reg.ext_mode_select_reg;
				urxfc_pkg::URXFC_RESUME_FIRST: s_next.rdData = s_reg.chars[0];
				urxfc_pkg::URXFC_RESUME_SECOND: s_next.rdData = s_reg.chars[1];
				urxfc_pkg::URXFC_PAUSE_FIRST: s_next.rdData = s_reg.chars[2];
				urxfc_pkg::URXFC_PAUSE_SECOND: s_next.rdData = s_reg.chars[3];
				urxfc_pkg::URXFC_TRIG_D: s_next.rdData = s_reg.trigD;
				urxfc_pkg::URXFC_HYST_D: s_next.rdData = s_reg.hystD;
				default: s_next.rdData = 8'h00; // Unmapped reads zero
			endcase
		end

		// Receive character sorting
		s_next.replayValid = 1'b0;
		if (inValid)
		begin
			if (isSpecial)
			begin
				// Special character goes to the FIFO and is flagged
				push = 1'b1;
				s_next.isrSpecial = 1'b1;
			end
			else if (s_reg.waitOff || s_reg.waitOn)
			begin
				// Second of a pair; no match releases the held one
				s_next.waitOff = 1'b0;
				s_next.waitOn = 1'b0;
				if (s_reg.waitOff && isOff2)
					doOff = 1'b1;
				else if (s_reg.waitOn && isOn2)
					doOn = 1'b1;
				else
				begin
					push = 1'b1;
					pushWord = s_reg.held;
					s_next.replayValid = 1'b1;
					s_next.replay = inWord;
				end
			end
			else
			begin
				unique case (s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_RXSW +: 2])
					2'd1:
					begin
						doOff = isOff1;
						doOn = isOn1 && !isOff1;
						push = !isOff1 && !isOn1;
					end
					2'd2:
					begin
						doOff = isOff2;
						doOn = isOn2 && !isOff2;
						push = !isOff2 && !isOn2;
					end
					2'd3:
					begin
						// Hold the first of a possible pair back
						s_next.waitOff = isOff1;
						s_next.waitOn = isOn1 && !isOff1;
						s_next.held = inWord;
						push = !isOff1 && !isOn1;
					end
					2'd0: push = 1'b1;
				endcase
			end
		end

		// Pause and resume of the local transmitter
		if (doOff)
		begin
			s_next.suspended = 1'b1;
			if (s_reg.int_enable_reg[urxfc_pkg::URXFC_IER_XOFF])
				s_next.isrSpecial = 1'b1;
		end
		if (doOn)
		begin
			s_next.suspended = 1'b0;
			s_next.isrSpecial = 1'b0;
		end

		// FIFO write, overrun when full, and host pop
		if (push)
		begin
			if (s_reg.count == urxfc_pkg::URXFC_FIFO_FULL)
				s_next.overrun = 1'b1;
			else
			begin
				pushOk = 1'b1;
				s_next.mem[s_reg.wrPtr] = pushWord;
				s_next.wrPtr = s_reg.wrPtr + 6'd1;
			end
		end
		if (popNow)
			s_next.rdPtr = s_reg.rdPtr + 6'd1;
		s_next.count = s_reg.count + {6'd0, pushOk} - {6'd0, popNow};

		// Auto RTS with hysteresis; FIFO keeps filling regardless
		if (!autoRts)
			s_next.rtsOff = 1'b0;
		else if (s_reg.count >= upLvl)
			s_next.rtsOff = 1'b1;
		else if (s_reg.count <= loLvl)
			s_next.rtsOff = 1'b0;

		// RTS pin: half-duplex direction wins over flow control
		if (s_reg.feature_ctrl_reg[urxfc_pkg::URXFC_FEATURE_CTRL_REG_RS485])
			s_next.rtsPin = !txActive ^
				s_reg.ext_mode_select_reg[urxfc_pkg::URXFC_EXT_MODE_SELECT_REG_INVERT];
		else if (autoRts)
			s_next.rtsPin = s_next.rtsOff;
		else
			s_next.rtsPin = !s_reg.modem_ctrl_reg[urxfc_pkg::URXFC_MCR_RTS];

		// Modem events: RTS rising, CTS deasserting
		if (!s_reg.rtsPin && s_next.rtsPin &&
			s_reg.int_enable_reg[urxfc_pkg::URXFC_IER_RTS] &&
			s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_UNLOCK])
			s_next.isrModem = 1'b1;
		if (s_reg.ctsSync && !s_reg.ctsPrev &&
			s_reg.int_enable_reg[urxfc_pkg::URXFC_IER_CTS] &&
			s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_UNLOCK])
			s_next.isrModem = 1'b1;

		// Transmitter holds off between characters while high
		s_next.halt = (s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_CTS] &&
			s_reg.ctsSync) || s_next.suspended;

		// Pause sending: arm on upward crossing, wait two characters
		s_next.prevAbove = above;
		if (txMode == 2'd0)
		begin
			s_next.xoffArmed = 1'b0;
			s_next.xoffSent = 1'b0;
		end
		else if (above && !s_reg.prevAbove && !s_reg.xoffSent &&
			!s_reg.xoffArmed)
		begin
			s_next.xoffArmed = 1'b1;
			s_next.xoffDelay = urxfc_pkg::URXFC_TWO_CHAR_BASE +
				{2'b00, s_reg.line_ctrl_reg[1:0], 1'b0};
		end
		else if (s_reg.xoffArmed && bitTick && s_reg.xoffDelay != 5'd0)
			s_next.xoffDelay = s_reg.xoffDelay - 5'd1;

		// Flow character sender
		unique case (s_reg.send)
			urxfc_pkg::URXFC_SEND_IDLE:
			begin
				if (s_reg.xoffArmed && s_reg.xoffDelay == 5'd0)
				begin
					s_next.xoffArmed = 1'b0;
					s_next.xoffSent = 1'b1;
					s_next.sendOff = 1'b1;
					s_next.send = (txMode == 2'd2) ?
						urxfc_pkg::URXFC_SEND_SECOND :
						urxfc_pkg::URXFC_SEND_FIRST;
					s_next.flowOut = (txMode == 2'd2) ?
						s_reg.chars[3] : s_reg.chars[2];
				end
				else if (s_reg.xoffSent && !s_reg.xoffArmed && xonCond &&
					txMode != 2'd0)
				begin
					s_next.xoffSent = 1'b0;
					s_next.sendOff = 1'b0;
					s_next.send = (txMode == 2'd2) ?
						urxfc_pkg::URXFC_SEND_SECOND :
						urxfc_pkg::URXFC_SEND_FIRST;
					s_next.flowOut = (txMode == 2'd2) ?
						s_reg.chars[1] : s_reg.chars[0];
				end
			end
			urxfc_pkg::URXFC_SEND_FIRST:
			begin
				if (flowAck)
				begin
					s_next.send = (txMode == 2'd3) ?
						urxfc_pkg::URXFC_SEND_SECOND :
						urxfc_pkg::URXFC_SEND_IDLE;
					s_next.flowOut = s_reg.sendOff ?
						s_reg.chars[3] : s_reg.chars[1];
				end
			end
			urxfc_pkg::URXFC_SEND_SECOND:
			begin
				if (flowAck)
					s_next.send = urxfc_pkg::URXFC_SEND_IDLE;
			end
			default: s_next.send = urxfc_pkg::URXFC_SEND_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
			s_reg.chars <= {4{urxfc_pkg::URXFC_CHAR_RST}};
			s_reg.int_enable_reg <= urxfc_pkg::URXFC_REG_RST;
			s_reg.rtsPin <= 1'b1;
			s_reg.ctsMeta <= 1'b1;
			s_reg.ctsSync <= 1'b1;
			s_reg.ctsPrev <= 1'b1;
			s_reg.send <= urxfc_pkg::URXFC_SEND_IDLE;
		end
		else
			s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign regRdData = s_reg.rdData;
	assign rtsPinN = s_reg.rtsPin;
	assign txHalt = s_reg.halt;
	assign flowChar = s_reg.flowOut;
	assign flowReq = s_reg.send != urxfc_pkg::URXFC_SEND_IDLE;
	assign intPending = s_reg.isrSpecial || s_reg.isrModem ||
		(s_reg.int_enable_reg[urxfc_pkg::URXFC_IER_RXRDY] &&
		s_reg.count >= trigLvl && s_reg.count != 7'h00);

	////////////////////////////////////////////////////////////////////////
	// Checks
	holdPop_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		popNow && !inValid |=> s_reg.count == $past(s_reg.count) - 7'd1)
	else $error("holding read did not pop one entry");

	lsrTags_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		regRd && regAddr == urxfc_pkg::URXFC_LINE_STATUS &&
		s_reg.count != 7'h00
		|=> regRdData[4:2] == $past(s_reg.mem[s_reg.rdPtr][10:8]))
	else $error("line status tags differ from head entry");

	ctsHalt_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_CTS] && s_reg.ctsSync |=> txHalt)
	else $error("CTS deasserted but transmitter not halted");

	rtsUpper_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		autoRts && !s_reg.feature_ctrl_reg[urxfc_pkg::URXFC_FEATURE_CTRL_REG_RS485] &&
		s_reg.count >= upLvl |=> ##1 rtsPinN)
	else $error("RTS not off at upper limit");

	rtsLower_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		autoRts && !s_reg.feature_ctrl_reg[urxfc_pkg::URXFC_FEATURE_CTRL_REG_RS485] &&
		s_reg.count <= loLvl && s_reg.count < upLvl
		|=> !s_reg.rtsOff)
	else $error("RTS not back on at lower limit");

	dirCtrl_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		s_reg.feature_ctrl_reg[urxfc_pkg::URXFC_FEATURE_CTRL_REG_RS485] && !regWr
		|=> rtsPinN == ($past(!txActive) ^
		s_reg.ext_mode_select_reg[urxfc_pkg::URXFC_EXT_MODE_SELECT_REG_INVERT]))
	else $error("direction output wrong");

	pauseStop_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		inValid && !isSpecial && !s_reg.waitOff && !s_reg.waitOn &&
		s_reg.enhanced_feature_reg[1:0] == 2'd1 && isOff1 && !popNow
		|=> txHalt && s_reg.count == $past(s_reg.count))
	else $error("pause char stored or transmit not halted");

	specialKeep_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		inValid && isSpecial && !popNow &&
		s_reg.count != urxfc_pkg::URXFC_FIFO_FULL
		|=> s_reg.count == $past(s_reg.count) + 7'd1 && s_reg.isrSpecial)
	else $error("special char not stored and flagged");

	resumeGo_a:
	assert property (@(posedge core_clk) disable iff (!nrst)
		inValid && !isSpecial && s_reg.waitOn && isOn2 &&
		!s_reg.enhanced_feature_reg[urxfc_pkg::URXFC_EFR_CTS]
		|=> !txHalt && !s_reg.isrSpecial)
	else $error("resume pair did not restart transmit");

endmodule : urxfc_top

`default_nettype wire

/* tb/test_urxfc_top.sv */
// Self-checking bench for the receive holding and flow control block.
// Assumes the remote model drives the receive and flow ports.
`timescale 1ns/1ps
`default_nettype none

module test_urxfc_top;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] regAddr = 5'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic txActive = 1'b0;
	logic ctsPinN = 1'b0;
	logic obeyRts = 1'b0;
	logic [7:0] regRdData, flowChar, rxChar, rd;
	logic rxCharValid, bitTick, rtsPinN, txHalt, flowReq, flowAck;
	logic intPending;
	logic [2:0] rxErrTags;
	int fails = 0;
	int n_checks = 0;
	always #12.5 core_clk = ~core_clk;
	urxfc_top dut (.core_clk, .nrst, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .rxCharValid, .rxChar, .rxErrTags, .bitTick,
		.txActive, .ctsPinN, .rtsPinN, .txHalt, .flowReq, .flowChar,
		.flowAck, .intPending);
	urxfc_remote rem (.core_clk, .rtsPinN, .obeyRts, .flowReq,
		.flowAck, .rxCharValid, .rxChar, .rxErrTags, .bitTick);
	////////////////////////////////////////////////////////////////////
	// Verdict and run end
	task summarize;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// Compare one value
	task chk(input string what, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("BAD %s exp %h seen %h", what, exp, seen);
			fails++;
		end
	endtask : chk
	// Register write, one strobe cycle
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	// Register read; data stands in the cycle after the strobe
	task rdr(input logic [4:0] a);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 rd = regRdData;
	endtask : rdr
	// Let some edges pass, then settle
	task nap(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : nap
	// Bounded wait for a flow char offer, counting bit ticks
	task waitReq(output int ticks);
		int k;
		ticks = 0;
		for (k = 0; k < 600 && flowReq !== 1'b1; k++)
		begin
			@(posedge core_clk);
			ticks += (bitTick === 1'b1);
		end
		if (k >= 600)
		begin
			fails++;
			summarize();
		end
	endtask : waitReq
	////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		for (int a = 10; a < 14; a++)
		begin
			rdr(a[4:0]);
			chk("flowchr", rd, 8'h00);
		end
		chk("rts", {7'h0, rtsPinN}, 8'h01);
		$display("reset done");
	endtask : t_reset
	// Fill past full, then drain checking data and tags
	task t_fifo;
		for (int i = 0; i < 65; i++)
			rem.send(i[7:0], i[2:0]);
		rdr(5'h0E);
		chk("level", rd, 8'h40);
		rdr(5'h00);
		chk("head", rd, 8'h00);
		rdr(5'h06);
		chk("tags", {5'h0, rd[4:2]}, 8'h01);
		chk("ovr", {7'h0, rd[1]}, 8'h01);
		for (int i = 1; i < 64; i++)
		begin
			rdr(5'h00);
			chk("data", rd, i[7:0]);
		end
		$display("fifo done");
	endtask : t_fifo
	// Pause and resume on 5-bit words; flow chars not stored
	task t_xoff;
		wr(5'h04, 8'h00);
		wr(5'h0C, 8'h13);
		wr(5'h0A, 8'h11);
		wr(5'h01, 8'h20);
		wr(5'h07, 8'h01);
		rem.send(8'hF3, 3'h0);
		nap(2);
		chk("halt", {7'h0, txHalt}, 8'h01);
		chk("int", {7'h0, intPending}, 8'h01);
		rem.send(8'hF1, 3'h0);
		nap(2);
		chk("halt", {7'h0, txHalt}, 8'h00);
		chk("int", {7'h0, intPending}, 8'h00);
		rdr(5'h0E);
		chk("level", rd, 8'h00);
		wr(5'h04, 8'h03);
		$display("xoff done");
	endtask : t_xoff
	// Auto CTS halt and modem event
	task t_cts;
		wr(5'h07, 8'h90);
		wr(5'h01, 8'h80);
		ctsPinN <= 1'b1;
		nap(4);
		chk("halt", {7'h0, txHalt}, 8'h01);
		rdr(5'h02);
		chk("isr5", {7'h0, rd[5]}, 8'h01);
		ctsPinN <= 1'b0;
		nap(4);
		chk("halt", {7'h0, txHalt}, 8'h00);
		$display("cts done");
	endtask : t_cts
	// Auto RTS on table B, trigger 16, limits 24 and 8
	task t_rts;
		wr(5'h03, 8'h50);
		wr(5'h07, 8'h50);
		wr(5'h01, 8'h41);
		wr(5'h05, 8'h02);
		nap(2);
		chk("rts", {7'h0, rtsPinN}, 8'h00);
		obeyRts <= 1'b1;
		for (int i = 0; i < 23; i++)
			rem.send(i[7:0], 3'h0);
		nap(2);
		chk("int", {7'h0, intPending}, 8'h01);
		chk("rts", {7'h0, rtsPinN}, 8'h00);
		rem.send(8'h77, 3'h0);
		nap(2);
		chk("rts", {7'h0, rtsPinN}, 8'h01);
		rdr(5'h02);
		chk("isr5", {7'h0, rd[5]}, 8'h01);
		fork
			rem.send(8'h55, 3'h0);
		join_none
		repeat (15) rdr(5'h00);
		nap(2);
		chk("rts", {7'h0, rtsPinN}, 8'h01);
		rdr(5'h00);
		nap(8);
		rdr(5'h0E);
		chk("level", rd, 8'h09);
		repeat (9) rdr(5'h00);
		obeyRts <= 1'b0;
		wr(5'h05, 8'h00);
		$display("rts done");
	endtask : t_rts
	// Pause sent two char times after crossing 8, resume when empty
	task t_send;
		int n;
		wr(5'h03, 8'h10);
		wr(5'h01, 8'h00);
		wr(5'h07, 8'h04);
		repeat (8) rem.send(8'h41, 3'h0);
		waitReq(n);
		chk("gap", {7'h0, n >= 19 && n <= 21}, 8'h01);
		chk("pause", flowChar, 8'h13);
		repeat (8) rdr(5'h00);
		waitReq(n);
		chk("resume", flowChar, 8'h11);
		wr(5'h07, 8'h00);
		$display("send done");
	endtask : t_send
	// Paired flow chars, a broken pair, then special char kept
	task t_dbl;
		wr(5'h0D, 8'h93);
		wr(5'h0B, 8'h91);
		wr(5'h07, 8'h03);
		rem.send(8'h13, 3'h0);
		rem.send(8'h93, 3'h0);
		nap(2);
		chk("halt", {7'h0, txHalt}, 8'h01);
		rem.send(8'h11, 3'h0);
		rem.send(8'h91, 3'h0);
		nap(2);
		chk("halt", {7'h0, txHalt}, 8'h00);
		rem.send(8'h13, 3'h0);
		rem.send(8'h42, 3'h0);
		nap(2);
		rdr(5'h0E);
		chk("level", rd, 8'h02);
		rdr(5'h00);
		chk("held", rd, 8'h13);
		rdr(5'h00);
		chk("next", rd, 8'h42);
		wr(5'h07, 8'h20);
		rem.send(8'h93, 3'h0);
		rdr(5'h02);
		chk("isr4", {7'h0, rd[4]}, 8'h01);
		rdr(5'h00);
		chk("special", rd, 8'h93);
		wr(5'h07, 8'h00);
		$display("dbl done");
	endtask : t_dbl
	// Half-duplex direction and its inversion
	task t_dir;
		wr(5'h08, 8'h08);
		txActive <= 1'b1;
		nap(3);
		chk("dir", {7'h0, rtsPinN}, 8'h00);
		txActive <= 1'b0;
		nap(3);
		chk("dir", {7'h0, rtsPinN}, 8'h01);
		wr(5'h09, 8'h08);
		nap(3);
		chk("dirinv", {7'h0, rtsPinN}, 8'h00);
		$display("dir done");
	endtask : t_dir
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_fifo();
		t_xoff();
		t_cts();
		t_rts();
		t_send();
		t_dbl();
		t_dir();
		summarize();
	end
endmodule : test_urxfc_top
`default_nettype wire

/* tb/urxfc_remote.sv */
// Remote station model: sends characters and takes flow characters.
// Assumes it shares core_clk with the block and the bench calls send.
`timescale 1ns/1ps
`default_nettype none

module urxfc_remote
(
	input wire logic core_clk,
	input wire logic rtsPinN,
	input wire logic obeyRts,
	input wire logic flowReq,
	output logic flowAck,
	output logic rxCharValid,
	output logic [7:0] rxChar,
	output logic [2:0] rxErrTags,
	output logic bitTick
);
	logic [1:0] div = 2'h0; // Bit time divider
	logic [1:0] ackWait = 2'h0; // Delay before taking a flow char
	initial
	begin
		flowAck = 1'b0;
		rxCharValid = 1'b0;
		rxChar = 8'h5A;
		rxErrTags = 3'h0;
		bitTick = 1'b0;
	end
	// One bit time every four cycles
	always @(posedge core_clk)
	begin
		div <= div + 2'h1;
		bitTick <= (div == 2'h3);
	end
	// Takes an offered flow char after a short delay
	always @(posedge core_clk)
	begin
		flowAck <= (ackWait == 2'h3);
		ackWait <= (flowReq && !flowAck && ackWait != 2'h3) ?
			ackWait + 2'h1 : 2'h0;
	end
	// One character; waits while RTS is off if told to obey it
	task automatic send(input logic [7:0] c, input logic [2:0] t);
		int k;
		k = 0;
		while (obeyRts && rtsPinN && k < 300)
		begin
			@(posedge core_clk);
			k++;
		end
		// RTS never came back on: count it and end the run
		if (k >= 300)
		begin
			test_urxfc_top.fails++;
			test_urxfc_top.summarize();
		end
		@(posedge core_clk);
		rxCharValid <= 1'b1;
		rxChar <= c;
		rxErrTags <= t;
		@(posedge core_clk);
		rxCharValid <= 1'b0;
		rxChar <= ~c; // Line released: show the inverse
		rxErrTags <= ~t;
		@(posedge core_clk);
	endtask : send
endmodule : urxfc_remote
`default_nettype wire
